// ==== vmeas_pkg.sv ====
package vmeas_pkg;
    // device register offsets (byte registers)
    localparam logic [7:0] DEV_LOCK_OFS = 8'h07;
    localparam logic [7:0] DEV_ACT_HI_OFS = 8'h0B;
    localparam logic [7:0] DEV_ACT_LO_OFS = 8'h0C;
    localparam logic [7:0] DEV_TOT_HI_OFS = 8'h28;
    localparam logic [7:0] DEV_TOT_LO_OFS = 8'h29;
    localparam logic [7:0] DEV_FP_HI_OFS = 8'h2C;
    localparam logic [7:0] DEV_FP_LO_OFS = 8'h2D;
    localparam logic [7:0] DEV_SW_HI_OFS = 8'h30;
    localparam logic [7:0] DEV_SW_LO_OFS = 8'h31;
    localparam logic [7:0] DEV_BP_HI_OFS = 8'h34;
    localparam logic [7:0] DEV_BP_LO_OFS = 8'h35;
    localparam logic [7:0] DEV_EXTRACT_OFS = 8'h4C;
    localparam logic [7:0] DEV_RAW_LOCK_OFS = 8'h6A;
    // device field positions
    localparam int LOCK_BIT = 7;
    localparam int SCAN_BIT = 5;
    localparam int ALT_BIT = 2;
    localparam int RAW_LOCK_BIT = 1;
    localparam int HALFLINE_W = 14;
    localparam int ACTIVE_W = 13;
    localparam logic ALT_RESET = 1'b0;
    // controller APB register byte addresses
    localparam logic [7:0] CTL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] TOT_OFS = 8'h08;
    localparam logic [7:0] ACT_OFS = 8'h0C;
    localparam logic [7:0] FP_OFS = 8'h10;
    localparam logic [7:0] SW_OFS = 8'h14;
    localparam logic [7:0] BP_OFS = 8'h18;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h1C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h20;
    // controller status bits
    localparam int ST_LOCK_BIT = 0;
    localparam int ST_SCAN_BIT = 1;
    localparam int ST_RAW_BIT = 2;
    // interrupt bits
    localparam int IRQ_LOCK_CHG_BIT = 0;
    localparam int IRQ_MEAS_CHG_BIT = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam int POLL_N = 12;
endpackage : vmeas_pkg

// ==== vmeas_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface vmeas_if;
    logic [7:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    modport device (input reg_addr, input reg_rd, input reg_wr, input reg_wdata,
                    output reg_rdata, output reg_ack);
    modport host (output reg_addr, output reg_rd, output reg_wr, output reg_wdata,
                  input reg_rdata, input reg_ack);
endinterface : vmeas_if
`default_nettype wire

// ==== sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sync2
`default_nettype wire

// ==== vmeas_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module vmeas_device #(
    parameter int NPORTS = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [2:0] port_sel,
    input wire logic [NPORTS-1:0] vsync_pin,
    input wire logic [NPORTS-1:0] hsync_pin,
    input wire logic [NPORTS-1:0] de_pin,
    vmeas_if.device bus
);
    localparam int HW = vmeas_pkg::HALFLINE_W;
    localparam int AW = vmeas_pkg::ACTIVE_W;

    initial begin
        if (NPORTS < 1 || NPORTS > 8) begin
            $error("vmeas_device: NPORTS must be 1 to 8");
        end
    end

    logic [3*NPORTS-1:0] pins_s;
    sync2 #(.W(3*NPORTS)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({de_pin, hsync_pin, vsync_pin}),
        .sync_out(pins_s)
    );

    logic vs;
    logic hs;
    logic de;
    always_comb begin
        vs = 1'b0;
        hs = 1'b0;
        de = 1'b0;
        if (32'(port_sel) < NPORTS) begin
            vs = pins_s[port_sel];
            hs = pins_s[NPORTS + 32'(port_sel)];
            de = pins_s[2*NPORTS + 32'(port_sel)];
        end
    end

    logic vs_q, hs_q, de_q;
    logic [2:0] port_q;
    logic alt_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            vs_q <= 1'b0;
            hs_q <= 1'b0;
            de_q <= 1'b0;
            port_q <= 3'h0;
        end else begin
            vs_q <= vs;
            hs_q <= hs;
            de_q <= de;
            port_q <= port_sel;
        end
    end
    wire logic vs_rise = vs & ~vs_q;
    wire logic vs_fall = ~vs & vs_q;
    wire logic de_rise = de & ~de_q;
    wire logic de_fall = ~de & de_q;
    wire logic port_chg = port_q != port_sel;

    // line timing; the alternative method flywheels on DE so blanking lines still tick
    logic [15:0] pix_q;
    logic [15:0] line_len_q;
    logic half_q;
    wire logic ref_edge = alt_q ? de_rise : (hs & ~hs_q);
    wire logic wrap = alt_q & (line_len_q != 16'h0) & (pix_q == line_len_q - 16'h1);
    wire logic line_tick = ref_edge | wrap;
    // pix_q lags the line edge by one, so the half-line point sits one count early
    wire logic mid_tick = ~line_tick & (line_len_q != 16'h0)
                          & (pix_q + 16'h1 == (line_len_q >> 1));
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pix_q <= 16'h0;
            line_len_q <= 16'h0;
            half_q <= 1'b0;
        end else if (line_tick) begin
            pix_q <= 16'h0;
            half_q <= 1'b0;
            if (ref_edge) begin
                line_len_q <= pix_q + 16'h1;
            end
        end else begin
            pix_q <= pix_q + 16'h1;
            if (mid_tick) begin
                half_q <= 1'b1;
            end
        end
    end

    // per-field stamps in half lines since the vsync leading edge
    logic [HW-1:0] hl_q, sync_end_q, act_start_q, act_end_q;
    logic [AW-1:0] lines_q;
    logic seen_de_q;
    logic cur_b_q;
    // count including this edge's tick, so a tick on a field edge closes the old field
    wire logic [HW-1:0] hl_end = ((line_tick | mid_tick) && hl_q != '1)
                                 ? hl_q + HW'(1) : hl_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hl_q <= '0;
            sync_end_q <= '0;
            act_start_q <= '0;
            act_end_q <= '0;
            lines_q <= '0;
            seen_de_q <= 1'b0;
            cur_b_q <= 1'b0;
        end else if (vs_rise) begin
            hl_q <= '0;
            lines_q <= '0;
            seen_de_q <= 1'b0;
            cur_b_q <= half_q;
        end else begin
            hl_q <= hl_end;
            if (vs_fall) begin
                sync_end_q <= hl_end;
            end
            if (de_rise) begin
                seen_de_q <= 1'b1;
                if (lines_q != '1) begin
                    lines_q <= lines_q + 1'b1;
                end
                if (!seen_de_q) begin
                    act_start_q <= hl_end;
                end
            end
            if (de_fall) begin
                act_end_q <= hl_end;
            end
        end
    end

    // lock filter and field b snapshot
    logic [HW-1:0] hist1_q, hist2_q;
    logic lock_q, interlaced_q, bvalid_q;
    logic [HW-1:0] tot_q, fp_q, sw_q, bp_q;
    logic [AW-1:0] act_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hist1_q <= '0;
            hist2_q <= '0;
            lock_q <= 1'b0;
            interlaced_q <= 1'b0;
            bvalid_q <= 1'b0;
        end else if (port_chg) begin
            hist1_q <= '0;
            hist2_q <= '0;
            lock_q <= 1'b0;
            bvalid_q <= 1'b0;
        end else if (vs_rise) begin
            hist1_q <= hl_end;
            hist2_q <= hist1_q;
            // two fields back is the same field of the previous frame
            lock_q <= (hl_end == hist2_q) && hl_end != '0;
            interlaced_q <= hl_end[0];
            if (hl_end != hist2_q) begin
                bvalid_q <= 1'b0;
            end else if (cur_b_q) begin
                bvalid_q <= 1'b1;
            end
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tot_q <= '0;
            act_q <= '0;
            fp_q <= '0;
            sw_q <= '0;
            bp_q <= '0;
        end else if (vs_rise && cur_b_q) begin
            tot_q <= hl_end;
            act_q <= lines_q;
            fp_q <= hl_end - act_end_q;
            sw_q <= sync_end_q;
            bp_q <= act_start_q - sync_end_q;
        end
    end
    wire logic raw_lock = lock_q & (~interlaced_q | bvalid_q);

    // register port; reading a high byte freezes its low byte for the following read
    logic [7:0] shadow_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            alt_q <= vmeas_pkg::ALT_RESET;
        end else if (bus.reg_wr && bus.reg_addr == vmeas_pkg::DEV_EXTRACT_OFS) begin
            alt_q <= bus.reg_wdata[vmeas_pkg::ALT_BIT];
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bus.reg_rdata <= 8'h00;
            bus.reg_ack <= 1'b0;
            shadow_q <= 8'h00;
        end else begin
            bus.reg_ack <= bus.reg_rd | bus.reg_wr;
            if (bus.reg_rd) begin
                bus.reg_rdata <= 8'h00;
                if (bus.reg_addr == vmeas_pkg::DEV_LOCK_OFS) begin
                    bus.reg_rdata[vmeas_pkg::LOCK_BIT] <= lock_q;
                end else if (bus.reg_addr == vmeas_pkg::DEV_RAW_LOCK_OFS) begin
                    bus.reg_rdata[vmeas_pkg::RAW_LOCK_BIT] <= raw_lock;
                end else if (bus.reg_addr == vmeas_pkg::DEV_ACT_HI_OFS) begin
                    bus.reg_rdata <= {2'b00, interlaced_q, act_q[12:8]};
                    shadow_q <= act_q[7:0];
                end else if (bus.reg_addr == vmeas_pkg::DEV_TOT_HI_OFS) begin
                    bus.reg_rdata <= {2'b00, tot_q[13:8]};
                    shadow_q <= tot_q[7:0];
                end else if (bus.reg_addr == vmeas_pkg::DEV_FP_HI_OFS) begin
                    bus.reg_rdata <= {2'b00, fp_q[13:8]};
                    shadow_q <= fp_q[7:0];
                end else if (bus.reg_addr == vmeas_pkg::DEV_SW_HI_OFS) begin
                    bus.reg_rdata <= {2'b00, sw_q[13:8]};
                    shadow_q <= sw_q[7:0];
                end else if (bus.reg_addr == vmeas_pkg::DEV_BP_HI_OFS) begin
                    bus.reg_rdata <= {2'b00, bp_q[13:8]};
                    shadow_q <= bp_q[7:0];
                end else if (bus.reg_addr == vmeas_pkg::DEV_ACT_LO_OFS
                             || bus.reg_addr == vmeas_pkg::DEV_TOT_LO_OFS
                             || bus.reg_addr == vmeas_pkg::DEV_FP_LO_OFS
                             || bus.reg_addr == vmeas_pkg::DEV_SW_LO_OFS
                             || bus.reg_addr == vmeas_pkg::DEV_BP_LO_OFS) begin
                    bus.reg_rdata <= shadow_q;
                end else if (bus.reg_addr == vmeas_pkg::DEV_EXTRACT_OFS) begin
                    bus.reg_rdata[vmeas_pkg::ALT_BIT] <= alt_q;
                end
            end
        end
    end
endmodule : vmeas_device
`default_nettype wire

// ==== vmeas_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module vmeas_host (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    vmeas_if.host bus
);
    typedef enum {ISSUE, WAIT_ACK} hstate_t;
    hstate_t state_q;
    logic [3:0] idx_q;
    logic wr_pend_q, alt_q, is_wr_q;
    logic [7:0] stage_q [vmeas_pkg::POLL_N];
    logic [7:0] view_q [vmeas_pkg::POLL_N];
    logic [1:0] irq_stat_q, irq_mask_q;

    function automatic logic [7:0] poll_addr(input logic [3:0] i);
        case (i)
            4'h0: poll_addr = vmeas_pkg::DEV_LOCK_OFS;
            4'h1: poll_addr = vmeas_pkg::DEV_RAW_LOCK_OFS;
            4'h2: poll_addr = vmeas_pkg::DEV_ACT_HI_OFS;
            4'h3: poll_addr = vmeas_pkg::DEV_ACT_LO_OFS;
            4'h4: poll_addr = vmeas_pkg::DEV_TOT_HI_OFS;
            4'h5: poll_addr = vmeas_pkg::DEV_TOT_LO_OFS;
            4'h6: poll_addr = vmeas_pkg::DEV_FP_HI_OFS;
            4'h7: poll_addr = vmeas_pkg::DEV_FP_LO_OFS;
            4'h8: poll_addr = vmeas_pkg::DEV_SW_HI_OFS;
            4'h9: poll_addr = vmeas_pkg::DEV_SW_LO_OFS;
            4'hA: poll_addr = vmeas_pkg::DEV_BP_HI_OFS;
            default: poll_addr = vmeas_pkg::DEV_BP_LO_OFS;
        endcase
    endfunction : poll_addr

    wire logic setup = psel & ~penable;
    wire logic access = psel & penable;
    wire logic wr_ctl = access & pwrite & (paddr == vmeas_pkg::CTL_OFS);
    wire logic round_end = (state_q == WAIT_ACK) & bus.reg_ack & ~is_wr_q
                           & (idx_q == 4'(vmeas_pkg::POLL_N - 1));

    // device sequencer: a pending control write is slipped in between poll reads
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ISSUE;
            idx_q <= 4'h0;
            bus.reg_addr <= 8'h00;
            bus.reg_rd <= 1'b0;
            bus.reg_wr <= 1'b0;
            bus.reg_wdata <= 8'h00;
            is_wr_q <= 1'b0;
        end else begin
            case (state_q)
                ISSUE: begin
                    if (wr_pend_q) begin
                        bus.reg_addr <= vmeas_pkg::DEV_EXTRACT_OFS;
                        bus.reg_wdata <= 8'(alt_q) << vmeas_pkg::ALT_BIT;
                        bus.reg_wr <= 1'b1;
                    end else begin
                        bus.reg_addr <= poll_addr(idx_q);
                        bus.reg_rd <= 1'b1;
                    end
                    // the write strobe is gone by the time its ack arrives
                    is_wr_q <= wr_pend_q;
                    state_q <= WAIT_ACK;
                end
                WAIT_ACK: begin
                    bus.reg_rd <= 1'b0;
                    if (bus.reg_ack) begin
                        bus.reg_wr <= 1'b0;
                        state_q <= ISSUE;
                        if (!is_wr_q) begin
                            idx_q <= round_end ? 4'h0 : idx_q + 4'h1;
                        end
                    end else if (bus.reg_wr) begin
                        bus.reg_wr <= 1'b0;
                    end
                end
                default: state_q <= ISSUE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            alt_q <= vmeas_pkg::ALT_RESET;
        end else begin
            if (wr_ctl) begin
                alt_q <= pwdata[0];
                wr_pend_q <= 1'b1;
            end else if (state_q == ISSUE && wr_pend_q) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // hi/lo pairs come from one device read pair; whole round becomes visible at once
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < vmeas_pkg::POLL_N; i++) begin
                stage_q[i] <= 8'h00;
                view_q[i] <= 8'h00;
            end
        end else if (state_q == WAIT_ACK && bus.reg_ack && !is_wr_q) begin
            stage_q[idx_q] <= bus.reg_rdata;
            if (round_end) begin
                for (int i = 0; i < vmeas_pkg::POLL_N - 1; i++) begin
                    view_q[i] <= stage_q[i];
                end
                view_q[vmeas_pkg::POLL_N - 1] <= bus.reg_rdata;
            end
        end
    end

    wire logic lock_s = view_q[0][vmeas_pkg::LOCK_BIT];
    wire logic raw_s = view_q[1][vmeas_pkg::RAW_LOCK_BIT];
    wire logic lock_new = stage_q[0][vmeas_pkg::LOCK_BIT];
    wire logic meas_new = {stage_q[2], stage_q[3], stage_q[4], stage_q[5]}
                          != {view_q[2], view_q[3], view_q[4], view_q[5]};
    logic [1:0] ev;
    always_comb begin
        ev = 2'h0;
        ev[vmeas_pkg::IRQ_LOCK_CHG_BIT] = round_end & (lock_new != lock_s);
        ev[vmeas_pkg::IRQ_MEAS_CHG_BIT] = round_end & meas_new;
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= vmeas_pkg::IRQ_MASK_RESET;
        end else begin
            // a new event wins over a write-one clear in the same cycle
            if (access && pwrite && paddr == vmeas_pkg::IRQ_STAT_OFS) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
            if (access && pwrite && paddr == vmeas_pkg::IRQ_MASK_OFS) begin
                irq_mask_q <= pwdata[1:0];
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // read data prepared in the setup cycle, presented with pready in the access cycle
    assign pready = 1'b1;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            if (paddr == vmeas_pkg::CTL_OFS) begin
                prdata[0] <= alt_q;
            end else if (paddr == vmeas_pkg::STAT_OFS) begin
                prdata[vmeas_pkg::ST_LOCK_BIT] <= lock_s;
                prdata[vmeas_pkg::ST_SCAN_BIT] <= view_q[2][vmeas_pkg::SCAN_BIT];
                prdata[vmeas_pkg::ST_RAW_BIT] <= raw_s;
            end else if (paddr == vmeas_pkg::ACT_OFS) begin
                prdata[12:0] <= {view_q[2][4:0], view_q[3]};
            end else if (paddr == vmeas_pkg::TOT_OFS) begin
                prdata[13:0] <= {view_q[4][5:0], view_q[5]};
            end else if (paddr == vmeas_pkg::FP_OFS) begin
                prdata[13:0] <= {view_q[6][5:0], view_q[7]};
            end else if (paddr == vmeas_pkg::SW_OFS) begin
                prdata[13:0] <= {view_q[8][5:0], view_q[9]};
            end else if (paddr == vmeas_pkg::BP_OFS) begin
                prdata[13:0] <= {view_q[10][5:0], view_q[11]};
            end else if (paddr == vmeas_pkg::IRQ_STAT_OFS) begin
                prdata[1:0] <= irq_stat_q;
            end else if (paddr == vmeas_pkg::IRQ_MASK_OFS) begin
                prdata[1:0] <= irq_mask_q;
            end else begin
                pslverr <= 1'b1;
            end
        end
    end
endmodule : vmeas_host
`default_nettype wire

// ==== vmeas_host_end.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== vmeas_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module vmeas_chk (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // a high byte of a half-line count has only six live bits
    property hi_clear(logic [7:0] a);
        reg_rd && reg_addr == a |=> (reg_rdata >> 6) == 8'h00;
    endproperty
    AST_ACK_NEXT: assert property ((reg_rd || reg_wr) |=> reg_ack)
        else $error("request not acknowledged one cycle later");
    AST_ACK_CAUSE: assert property (reg_ack |-> $past(reg_rd || reg_wr))
        else $error("acknowledge without a request");
    AST_ONE_KIND: assert property (!(reg_rd && reg_wr))
        else $error("read and write together");
    AST_WR_EXTRACT: assert property (reg_wr |-> reg_addr == vmeas_pkg::DEV_EXTRACT_OFS)
        else $error("write to a register other than extraction select");
    AST_RDATA_HOLD: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_TOT_HI: assert property (hi_clear(vmeas_pkg::DEV_TOT_HI_OFS))
        else $error("total high byte wider than six bits");
    AST_ACT_HI: assert property (hi_clear(vmeas_pkg::DEV_ACT_HI_OFS))
        else $error("active high byte has stray bits");
    AST_FP_HI: assert property (hi_clear(vmeas_pkg::DEV_FP_HI_OFS))
        else $error("front porch high byte wider than six bits");
    AST_SW_HI: assert property (hi_clear(vmeas_pkg::DEV_SW_HI_OFS))
        else $error("sync width high byte wider than six bits");
    AST_BP_HI: assert property (hi_clear(vmeas_pkg::DEV_BP_HI_OFS))
        else $error("back porch high byte wider than six bits");
    cover property (reg_rd && reg_addr == vmeas_pkg::DEV_TOT_HI_OFS);
    cover property (reg_wr && reg_wdata[vmeas_pkg::ALT_BIT]);
    cover property (reg_ack ##1 reg_ack);
endmodule : vmeas_chk
`default_nettype wire

// ==== test_vertical_sync_field_measure.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_vertical_sync_field_measure;
    localparam int L = 40;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] port_sel = 3'h0;
    logic [3:0] vsync_pin = 4'h0, hsync_pin = 4'h0, de_pin = 4'h0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, err;
    int fail_count = 0, samples_checked = 0, cyc = 0, seed = 43929;
    int hc = 0, fc = 0, flen = 400, n = 10, jx = 0;
    logic jit = 1'b0;
    vmeas_if bus_if();
    vmeas_device u_vmeas_device (.clock(clock), .sys_rst(sys_rst), .port_sel(port_sel),
        .vsync_pin(vsync_pin), .hsync_pin(hsync_pin), .de_pin(de_pin), .bus(bus_if.device));
    vmeas_host u_vmeas_host (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .bus(bus_if.host));
    vmeas_chk u_vmeas_chk (.clock(clock), .sys_rst(sys_rst), .reg_addr(bus_if.reg_addr),
        .reg_rd(bus_if.reg_rd), .reg_wr(bus_if.reg_wr), .reg_wdata(bus_if.reg_wdata),
        .reg_rdata(bus_if.reg_rdata), .reg_ack(bus_if.reg_ack));
    initial forever #2 clock = ~clock;
    // port 0 carries video, the others noise; port 1 keeps vsync low so its lock is known
    always @(posedge clock) begin
        logic [3:0] v, h, d;
        v = $random(seed);
        h = $random(seed);
        d = $random(seed);
        v[0] = fc < 3 * L;
        v[1] = 1'b0;
        h[0] = hc < 4;
        // active lines 5 to n-2 of each field
        d[0] = hc >= 8 && hc < 36 && fc >= 5 * L && fc < (n - 1) * L;
        vsync_pin <= v;
        hsync_pin <= h;
        de_pin <= d;
        hc <= (hc == L - 1) ? 0 : hc + 1;
        if (fc >= flen - 1 + jx) begin
            fc <= 0;
            jx <= jit ? (jx + L) % (4 * L) : 0;
        end else begin
            fc <= fc + 1;
        end
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fail_count++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // irq follows its status flops combinationally, from the same edge as the write that moves them
    task automatic irqchk(input logic exp);
        @(posedge clock);
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irqchk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic setv(input int nn, input logic il, input logic jj);
        n = nn;
        flen <= il ? (2 * nn + 1) * L / 2 : nn * L;
        jit <= jj;
    endtask : setv
    // slack covers one full polling round of the host
    task automatic fields(input int k);
        repeat (k * (flen + 2 * L) + 100) @(posedge clock);
    endtask : fields
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        apb(1'b1, vmeas_pkg::IRQ_MASK_OFS, 32'h1);
        setv(8 + ($random(seed) & 7), 1'b0, 1'b0);
        fields(6);
        rdchk(vmeas_pkg::STAT_OFS, 32'h5);
        rdchk(vmeas_pkg::TOT_OFS, 2 * n);
        rdchk(vmeas_pkg::SW_OFS, 32'h6);
        irqchk(1'b1);
        apb(1'b1, vmeas_pkg::IRQ_STAT_OFS, 32'h1);
        irqchk(1'b0);
        $display("test progressive done");
        setv(n, 1'b1, 1'b0);
        fields(8);
        rdchk(vmeas_pkg::STAT_OFS, 32'h7);
        rdchk(vmeas_pkg::TOT_OFS, 2 * n + 1);
        rdchk(vmeas_pkg::SW_OFS, 32'h6);
        // field b: sync lines 0 to 2, two blank lines each side of the active lines
        rdchk(vmeas_pkg::ACT_OFS, n - 6);
        rdchk(vmeas_pkg::FP_OFS, 32'h4);
        rdchk(vmeas_pkg::BP_OFS, 32'h4);
        $display("test interlaced done");
        apb(1'b1, vmeas_pkg::CTL_OFS, 32'h1);
        rdchk(vmeas_pkg::CTL_OFS, 32'h1);
        fields(6);
        apb(1'b0, vmeas_pkg::STAT_OFS, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        apb(1'b1, vmeas_pkg::CTL_OFS, 32'h0);
        $display("test alternative extraction done");
        apb(1'b1, vmeas_pkg::IRQ_STAT_OFS, 32'h3);
        setv(n, 1'b1, 1'b1);
        fields(5);
        apb(1'b0, vmeas_pkg::STAT_OFS, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        irqchk(1'b1);
        $display("test unlock done");
        setv(n, 1'b0, 1'b0);
        fields(6);
        apb(1'b0, vmeas_pkg::STAT_OFS, 32'h0);
        chk({31'h0, rd[0]}, 32'h1);
        port_sel <= 3'h1;
        fields(4);
        apb(1'b0, vmeas_pkg::STAT_OFS, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        port_sel <= 3'h7;
        fields(3);
        apb(1'b0, vmeas_pkg::STAT_OFS, 32'h0);
        chk({31'h0, rd[0]}, 32'h0);
        $display("test port select done");
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, vmeas_pkg::IRQ_MASK_OFS, 32'h0);
        irqchk(1'b0);
        $display("test refusal and mask done");
        print_verdict();
    end
endmodule : test_vertical_sync_field_measure
`default_nettype wire
